// ===== verilog/bus_model_pkg.sv
package bus_model_pkg;

  // command opcodes of the script language
  typedef enum logic [2:0]
  {
    OP_MEMMAP    = 3'h0,
    OP_WRITE     = 3'h1,
    OP_READ      = 3'h2,
    OP_READCHECK = 3'h3,
    OP_POLL      = 3'h4,
    OP_WAIT      = 3'h5,
    OP_WAITFAST  = 3'h6,
    OP_WAITNORM  = 3'h7
  } opcode_t;

  // access width codes: word, halfword, byte
  typedef enum logic [1:0]
  {
    WIDTH_B = 2'h0,
    WIDTH_H = 2'h1,
    WIDTH_W = 2'h2
  } width_code_t;

  // next-cycle kind announced on the native bus
  localparam logic [1:0] CYCLE_INTERNAL = 2'h0;
  localparam logic [1:0] CYCLE_NONSEQ   = 2'h2;
  localparam logic [1:0] CYCLE_SEQ      = 2'h3;

  // bus size encodings
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  localparam int LABEL_BITS = 4;
  localparam int ADDR_BITS  = 32;
  localparam int DATA_BITS  = 32;

  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

endpackage : bus_model_pkg

// ===== verilog/lane_steer.sv
`timescale 1ns/1ps
// places narrow write data on lanes and extracts narrow read data from lanes
module lane_steer
  import bus_model_pkg::*;
(
  input  wire logic [1:0]  width,
  input  wire logic [1:0]  addr_low,
  input  wire logic        big_end,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] wdata_lanes,
  input  wire logic [31:0] rdata_lanes,
  output logic      [31:0] rdata_out
);

  // byte lane index for a given address under the selected byte order
  function automatic logic [1:0] lane_of(input logic [1:0] a, input logic [1:0] w,
                                         input logic be);
    logic [1:0] l;
    l = a;
    if (be)
    begin
      if (w == WIDTH_H)
        l = {~a[1], 1'b0};
      else
        l = ~a;
    end
    return l;
  endfunction : lane_of

  logic [1:0] lane;

  // replicate narrow data over all lanes, then pick the addressed lane on read
  always_comb
  begin
    lane = lane_of(addr_low, width, big_end);
    case (width)
      WIDTH_B:
      begin
        wdata_lanes = {4{wdata_in[7:0]}};
        rdata_out   = {24'h000000, rdata_lanes[8*lane +: 8]};
      end
      WIDTH_H:
      begin
        wdata_lanes = {2{wdata_in[15:0]}};
        rdata_out   = {16'h0000, rdata_lanes[16*lane[1] +: 16]};
      end
      default:
      begin
        wdata_lanes = wdata_in;
        rdata_out   = rdata_lanes;
      end
    endcase
  end

endmodule : lane_steer

// ===== verilog/scripted_bus_master_model.sv
`timescale 1ns/1ps
// Behaviour
// - labels map to base addresses, offsets added
// - write issues one bus write
// - W/H/B codes drive matching bus size
// - read issues one unchecked bus read
// - readcheck compares data, mismatch records failure
// - end of run shows pass or fail
// - poll rereads until data AND mask equals mask
// - wait stalls N enabled clocks, no bus cycles
// - waitfiq resumes on fast interrupt falling edge
// - waitirq resumes on normal interrupt falling edge
// - byte order selects narrow read data lane
// - native bus cycle timing, no instruction decode
// - drives cycle kind, address, data, direction, size
module scripted_bus_master_model
  import bus_model_pkg::*;
#(
  parameter int LABELS = 16
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // script command port
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire bus_model_pkg::opcode_t  cmd_op,
  input  wire logic [1:0]              cmd_width,
  input  wire logic [LABEL_BITS-1:0]   cmd_label,
  input  wire logic [31:0]             cmd_offset,
  input  wire logic [31:0]             cmd_data,
  input  wire logic                    run_end,
  // native bus
  input  wire logic                    clock_gate_enable,
  output logic      [31:0]             addr,
  output logic      [31:0]             wdata,
  input  wire logic [31:0]             rdata,
  output logic      [1:0]              cycle_kind,
  output logic                         write,
  output logic      [1:0]              size,
  input  wire logic                    byte_order_select,
  input  wire logic                    fast_interrupt_n,
  input  wire logic                    normal_interrupt_n,
  // results
  output logic                         run_done,
  output logic                         run_pass,
  output logic                         check_fail,
  output logic      [31:0]             last_read
);
  import bus_model_pkg::*;

  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'h0,
    ST_ANNOUNCE = 3'h1,
    ST_DATA     = 3'h3,
    ST_WAIT     = 3'h2,
    ST_IRQ      = 3'h6,
    ST_DONE     = 3'h4
  } state_t;

  //////////////////////////////////////////////////////////////////////////////
  // label table and registered state

  logic [31:0]   base_table [LABELS];
  logic [31:0]   next_base_entry;
  logic          base_we;
  state_t        state, next_state;
  opcode_t       op, next_op;
  logic [1:0]    width, next_width;
  logic [31:0]   acc_addr, next_acc_addr;
  logic [31:0]   acc_data, next_acc_data;
  logic [31:0]   count, next_count;
  logic          fail, next_fail;
  logic          done, next_done;
  logic [31:0]   next_last_read;
  logic          fast_d, normal_d;
  logic [31:0]   steered_wdata;
  logic [31:0]   steered_rdata;

  lane_steer u_lane_steer
  (
    .width       (width),
    .addr_low    (acc_addr[1:0]),
    .big_end     (byte_order_select),
    .wdata_in    (acc_data),
    .wdata_lanes (steered_wdata),
    .rdata_lanes (rdata),
    .rdata_out   (steered_rdata)
  );

  function automatic logic [1:0] size_of(input logic [1:0] w);
    case (w)
      WIDTH_B: return SIZE_BYTE;
      WIDTH_H: return SIZE_HALF;
      default: return SIZE_WORD;
    endcase
  endfunction : size_of

  // falling edges of the interrupt lines; inputs are already synchronous
  logic fast_fall;
  logic normal_fall;
  assign fast_fall   = fast_d & ~fast_interrupt_n;
  assign normal_fall = normal_d & ~normal_interrupt_n;

  // ready drops while the run is being ended, so a command is never taken and then lost
  assign cmd_ready = (state == ST_IDLE) && !done && !run_end;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: one command at a time, each bus step advances on enabled clocks

  always_comb
  begin
    next_state      = state;
    next_op         = op;
    next_width      = width;
    next_acc_addr   = acc_addr;
    next_acc_data   = acc_data;
    next_count      = count;
    next_fail       = fail;
    next_done       = done;
    next_last_read  = last_read;
    next_base_entry = cmd_data;
    base_we         = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (run_end && !done)
        begin
          next_done  = 1'b1;
          next_state = ST_DONE;
        end
        else if (cmd_valid && !done)
        begin
          next_op       = cmd_op;
          next_width    = cmd_width;
          next_acc_addr = base_table[cmd_label] + cmd_offset;
          next_acc_data = cmd_data;
          next_count    = cmd_data;
          case (cmd_op)
            OP_MEMMAP:   base_we    = 1'b1;
            OP_WAIT:     next_state = (cmd_data == 32'h0000_0000) ? ST_IDLE : ST_WAIT;
            OP_WAITFAST: next_state = ST_IRQ;
            OP_WAITNORM: next_state = ST_IRQ;
            default:     next_state = ST_ANNOUNCE;
          endcase
        end
      end
      // non-sequential cycle announced; data phase follows next enabled edge
      ST_ANNOUNCE:
      begin
        if (clock_gate_enable)
          next_state = ST_DATA;
      end
      // data phase completes on the enabled edge
      ST_DATA:
      begin
        if (clock_gate_enable)
        begin
          next_state = ST_IDLE;
          if (op != OP_WRITE)
            next_last_read = steered_rdata;
          if (op == OP_READCHECK && steered_rdata != acc_data)
            next_fail = 1'b1;
          if (op == OP_POLL && (steered_rdata & acc_data) != acc_data)
            next_state = ST_ANNOUNCE;
        end
      end
      // idle clocks without bus activity
      ST_WAIT:
      begin
        if (clock_gate_enable)
        begin
          next_count = count - 32'h0000_0001;
          if (count == 32'h0000_0001)
            next_state = ST_IDLE;
        end
      end
      ST_IRQ:
      begin
        if ((op == OP_WAITFAST && fast_fall) || (op == OP_WAITNORM && normal_fall))
          next_state = ST_IDLE;
      end
      ST_DONE:
      begin
        next_state = ST_DONE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state     <= ST_IDLE;
      op        <= OP_MEMMAP;
      width     <= WIDTH_W;
      acc_addr  <= ADDR_RESET;
      acc_data  <= DATA_RESET;
      count     <= DATA_RESET;
      fail      <= 1'b0;
      done      <= 1'b0;
      last_read <= DATA_RESET;
      fast_d    <= 1'b1;
      normal_d  <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      op        <= next_op;
      width     <= next_width;
      acc_addr  <= next_acc_addr;
      acc_data  <= next_acc_data;
      count     <= next_count;
      fail      <= next_fail;
      done      <= next_done;
      last_read <= next_last_read;
      fast_d    <= fast_interrupt_n;
      normal_d  <= normal_interrupt_n;
    end
  end

  // the table is not reset; an unbound label reads whatever was stored last
  always_ff @(posedge sys_clk)
  begin
    if (base_we)
      base_table[cmd_label] <= next_base_entry;
  end

  //////////////////////////////////////////////////////////////////////////////
  // native bus outputs

  // kind of the next cycle: non-sequential while announcing, internal otherwise
  assign cycle_kind = (state == ST_ANNOUNCE) ? CYCLE_NONSEQ : CYCLE_INTERNAL;
  assign addr       = acc_addr;
  assign size       = size_of(width);
  assign write      = (op == OP_WRITE) && (state == ST_ANNOUNCE || state == ST_DATA);
  assign wdata      = steered_wdata;

  assign check_fail = fail;
  assign run_done   = done;
  assign run_pass   = done && !fail;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_wait_quiet;
    @(posedge sys_clk) disable iff (srst)
      state == ST_WAIT |-> cycle_kind == CYCLE_INTERNAL && !write;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet)
    else $error("bus cycle during wait");

  property p_size_match;
    @(posedge sys_clk) disable iff (srst)
      state == ST_DATA |-> (width == WIDTH_B) ? size == SIZE_BYTE :
                           (width == WIDTH_H) ? size == SIZE_HALF :
                           size == SIZE_WORD;
  endproperty
  a_size_match: assert property (p_size_match)
    else $error("size does not match width");

  property p_mismatch_fails;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_DATA && clock_gate_enable && op == OP_READCHECK
       && steered_rdata != acc_data) |=> fail;
  endproperty
  a_mismatch_fails: assert property (p_mismatch_fails)
    else $error("mismatch not recorded");

  property p_pass_flag;
    @(posedge sys_clk) disable iff (srst)
      check_fail |=> check_fail && !run_pass;
  endproperty
  a_pass_flag: assert property (p_pass_flag)
    else $error("failure not kept until end of run");

  property p_poll_retry;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_DATA && clock_gate_enable && op == OP_POLL
       && (steered_rdata & acc_data) != acc_data) |=> state == ST_ANNOUNCE;
  endproperty
  a_poll_retry: assert property (p_poll_retry)
    else $error("poll stopped early");

  property p_fast_resume;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_IRQ && op == OP_WAITFAST && fast_fall) |=> state == ST_IDLE;
  endproperty
  a_fast_resume: assert property (p_fast_resume)
    else $error("fast interrupt wait did not resume");

  property p_norm_hold;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_IRQ && op == OP_WAITNORM && !normal_fall) |=> state == ST_IRQ;
  endproperty
  a_norm_hold: assert property (p_norm_hold)
    else $error("normal interrupt wait left early");

  property p_in_order;
    @(posedge sys_clk) disable iff (srst)
      (cmd_valid && cmd_ready && cmd_op != OP_MEMMAP && cmd_op != OP_WAIT)
        |=> !cmd_ready;
  endproperty
  a_in_order: assert property (p_in_order)
    else $error("command taken while busy");

  property p_write_dir;
    @(posedge sys_clk) disable iff (srst)
      (state == ST_ANNOUNCE && op == OP_WRITE) |-> write && cycle_kind == CYCLE_NONSEQ;
  endproperty
  a_write_dir: assert property (p_write_dir)
    else $error("write cycle without direction");

endmodule : scripted_bus_master_model

// ===== testbench/bus_slave_model.sv
`timescale 1ns/1ps
// memory slave on the far side; word 15 returns how often it was read
module bus_slave_model
  import bus_model_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        write,
  input  wire logic [1:0]  cycle_kind,
  input  wire logic        clock_gate_enable,
  output logic      [31:0] rdata
);
  logic [31:0] mem [16];
  logic [31:0] polls;
  logic [31:0] held;
  logic [3:0]  idx;
  logic        wr;
  logic        data_ph;
  //////////////////////////////////////////////////////////////////////
  // data phase follows the announce and ends on an enabled edge only
  always @(posedge sys_clk)
  begin
    held <= rdata;
    if (srst)
    begin
      data_ph <= 1'b0;
      polls   <= 32'h0;
    end
    else if (cycle_kind == CYCLE_NONSEQ)
    begin
      data_ph <= 1'b1;
      idx     <= addr[5:2];
      wr      <= write;
    end
    else if (data_ph && clock_gate_enable)
    begin
      data_ph <= 1'b0;
      if (wr)
        mem[idx] <= wdata;
      else if (idx == 4'hF)
        polls <= polls + 32'h1;
    end
  end
  // released bus shows the inverse of the last value, never a stale match
  assign rdata = !data_ph ? ~held : (idx == 4'hF) ? polls : mem[idx];
endmodule : bus_slave_model

// ===== testbench/scripted_bus_master_model_tb.sv
`timescale 1ns/1ps
module scripted_bus_master_model_tb;
  import bus_model_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        cmd_valid = 1'b0;
  opcode_t     cmd_op = OP_MEMMAP;
  logic [1:0]  cmd_width = 2'h0;
  logic [3:0]  cmd_label = 4'h0;
  logic [31:0] cmd_offset = 32'h0;
  logic [31:0] cmd_data = 32'h0;
  logic        run_end = 1'b0;
  logic        clock_gate_enable = 1'b1;
  logic        byte_order_select = 1'b0;
  logic        fast_interrupt_n = 1'b1;
  logic        normal_interrupt_n = 1'b1;
  logic        cmd_ready, write, run_done, run_pass, check_fail, ann_write, prev_ann;
  logic [31:0] addr, wdata, rdata, last_read, ann_addr, seen_wdata;
  logic [1:0]  cycle_kind, size, ann_size;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n_ann = 0;
  int          busy;
  //////////////////////////////////////////////////////////////////////
  always #10 sys_clk = ~sys_clk;
  scripted_bus_master_model i_dut (.sys_clk, .srst, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_width, .cmd_label, .cmd_offset, .cmd_data, .run_end, .clock_gate_enable,
    .addr, .wdata, .rdata, .cycle_kind, .write, .size, .byte_order_select,
    .fast_interrupt_n, .normal_interrupt_n, .run_done, .run_pass, .check_fail, .last_read);
  bus_slave_model i_slave (.sys_clk, .srst, .addr, .wdata, .write, .cycle_kind,
    .clock_gate_enable, .rdata);
  // bus monitor: counts announces, keeps the qualifiers and data-phase wdata
  always @(posedge sys_clk)
  begin
    prev_ann <= (cycle_kind === CYCLE_NONSEQ);
    if (cycle_kind === CYCLE_NONSEQ)
    begin
      n_ann     <= n_ann + 1;
      ann_addr  <= addr;
      ann_size  <= size;
      ann_write <= write;
    end
    if (prev_ann)
      seen_wdata <= wdata;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  // wait bounded for idle, counting busy cycles after the taking edge
  task automatic wait_idle(input int limit);
    busy = 0;
    forever
    begin
      #1;
      if (cmd_ready === 1'b1)
        break;
      busy++;
      if (busy > limit)
      begin
        check(32'h0, 32'h1, "idle timeout");
        test_done();
      end
      @(posedge sys_clk);
    end
  endtask : wait_idle
  task automatic issue(input opcode_t op, input logic [1:0] w, input logic [3:0] lbl,
                       input logic [31:0] off, input logic [31:0] d);
    int   n;
    logic taken;
    @(posedge sys_clk);
    {cmd_op, cmd_width, cmd_label, cmd_offset, cmd_data} <= {op, w, lbl, off, d};
    cmd_valid <= 1'b1;
    n = 0;
    taken = 1'b0;
    do
    begin
      // ready is looked at before the edge, where the design samples the handshake
      @(negedge sys_clk);
      taken = (cmd_ready === 1'b1);
      @(posedge sys_clk);
      n++;
    end
    while (!taken && n < 50);
    cmd_valid <= 1'b0;
    if (n >= 50)
    begin
      check(32'h0, 32'h1, "not taken");
      test_done();
    end
  endtask : issue
  task automatic run_cmd(input opcode_t op, input logic [1:0] w, input logic [3:0] lbl,
                         input logic [31:0] off, input logic [31:0] d);
    issue(op, w, lbl, off, d);
    wait_idle(60);
  endtask : run_cmd
  //////////////////////////////////////////////////////////////////////
  task automatic test_access();
    int a;
    a = n_ann;
    run_cmd(OP_MEMMAP, WIDTH_W, 4'h3, 32'h0, 32'h40);
    check(32'(n_ann - a), 32'h0, "memmap bus");
    run_cmd(OP_WRITE, WIDTH_W, 4'h3, 32'h8, 32'h11223344);
    check(ann_addr, 32'h48, "write addr");
    check(32'({ann_write, ann_size}), 32'({1'b1, SIZE_WORD}), "write ctl");
    check(seen_wdata, 32'h11223344, "wdata");
    check(32'(n_ann - a), 32'h1, "one write");
    run_cmd(OP_READCHECK, WIDTH_W, 4'h3, 32'h8, 32'h11223344);
    check(last_read, 32'h11223344, "read");
    check(32'(check_fail), 32'h0, "good check");
    check(32'(busy), 32'h2, "read walk");
    check(32'(ann_write), 32'h0, "read dir");
    $display("test_access done");
  endtask : test_access
  task automatic test_lanes();
    logic [31:0] off [4] = '{32'h9, 32'h9, 32'hA, 32'hA};
    logic [31:0] exp [4] = '{32'h33, 32'h22, 32'h1122, 32'h3344};
    logic [31:0] msk [4] = '{32'hFF, 32'hFF, 32'hFFFF, 32'hFFFF};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      byte_order_select <= i[0];
      run_cmd(OP_READ, (i < 2) ? WIDTH_B : WIDTH_H, 4'h3, off[i], 32'h0);
      check(last_read & msk[i], exp[i], "lane");
      check(32'(ann_size), (i < 2) ? 32'(SIZE_BYTE) : 32'(SIZE_HALF), "size");
    end
    check(32'(check_fail), 32'h0, "read unchecked");
    run_cmd(OP_WRITE, WIDTH_B, 4'h3, 32'hC, 32'h5A);
    check(seen_wdata, 32'h5A5A5A5A, "byte lanes");
    check(ann_addr, 32'h4C, "byte addr");
    $display("test_lanes done");
  endtask : test_lanes
  // status word counts up, so only the fifth read has mask bit 2 set
  task automatic test_poll();
    int a;
    a = n_ann;
    run_cmd(OP_POLL, WIDTH_W, 4'h3, 32'h3C, 32'h4);
    check(32'(n_ann - a), 32'h5, "poll reads");
    $display("test_poll done");
  endtask : test_poll
  task automatic test_wait();
    int a;
    a = n_ann;
    issue(OP_WAIT, WIDTH_W, 4'h0, 32'h0, 32'd10);
    clock_gate_enable <= 1'b0;
    fork
      begin
        repeat (3) @(posedge sys_clk);
        clock_gate_enable <= 1'b1;
      end
    join_none
    wait_idle(60);
    check(32'(busy), 32'd13, "wait length");
    check(32'(n_ann - a), 32'h0, "wait quiet");
    run_cmd(OP_WAIT, WIDTH_W, 4'h0, 32'h0, 32'h0);
    check(32'(busy), 32'h0, "wait zero");
    $display("test_wait done");
  endtask : test_wait
  // the other line falls first and must not release the wait
  task automatic test_irq();
    opcode_t ops [2] = '{OP_WAITFAST, OP_WAITNORM};
    for (int i = 0; i < 2; i++)
    begin
      issue(ops[i], WIDTH_W, 4'h0, 32'h0, 32'h0);
      repeat (2) @(posedge sys_clk);
      fast_interrupt_n <= (i == 0);
      normal_interrupt_n <= (i == 1);
      repeat (3) @(posedge sys_clk);
      #1;
      check(32'(cmd_ready), 32'h0, "wrong line");
      @(posedge sys_clk);
      fast_interrupt_n <= (i == 1);
      normal_interrupt_n <= (i == 0);
      wait_idle(4);
      check(32'(busy), 32'h1, "resume");
      @(posedge sys_clk);
      {fast_interrupt_n, normal_interrupt_n} <= 2'h3;
    end
    $display("test_irq done");
  endtask : test_irq
  task automatic test_end(input logic [31:0] exp, input logic pass);
    run_cmd(OP_READCHECK, WIDTH_W, 4'h3, 32'h8, exp);
    check(32'(check_fail), 32'(!pass), "fail flag");
    @(posedge sys_clk);
    run_end <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(32'({run_done, run_pass}), 32'({1'b1, pass}), "verdict");
    check(32'(cmd_ready), 32'h0, "refused");
    @(posedge sys_clk);
    {srst, run_end} <= 2'h2;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    $display("test_end done");
  endtask : test_end
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    test_access();
    test_lanes();
    test_poll();
    test_wait();
    test_irq();
    test_end(32'h11223345, 1'b0);
    test_end(32'h11223344, 1'b1);
    test_done();
  end
endmodule : scripted_bus_master_model_tb
